// ### hw/slg_servo_config.sv
// Servo current limits, dead band in-position output and derivative gain scaling.
`timescale 1ns/1ps
`include "slg_defines.svh"

// Notes on behaviour
// - With motor on, average current above its limit disables amplifier, flags error.
// - Motor current above peak limit (reset 8.5 A) disables amplifier, flags error.
// - Queued average-limit update runs in order; immediate one applies at once.
// - Queued peak-limit update equals immediate one but runs in queue order.
// - Dead band update stores new width in steps, 0 to 167772160, default 0.
// - With in-position output enabled, output is high while error exceeds dead band.
// - In-position output is low while error magnitude is within the dead band.
// - Derivative percentage 0 to 99, default 30, scales maximum into effective gain.
// - Derivative maximum 0 to 32767, default 400, replaces the stored maximum.
// - Queued derivative percentage update equals immediate one, run in queue order.
// - Queued derivative maximum update equals immediate one, run in queue order.
module slg_servo_config #(
  parameter int QUEUE_DEPTH = 16,
  parameter int QCW         = $clog2(QUEUE_DEPTH + 1)
) (
  input  wire logic                   CLK_IN,
  input  wire logic                   RST_B_IN,
  input  wire logic                   HSEL_IN,
  input  wire logic [31:0]            HADDR_IN,
  input  wire logic [1:0]             HTRANS_IN,
  input  wire logic                   HWRITE_IN,
  input  wire logic [2:0]             HSIZE_IN,
  input  wire logic [31:0]            HWDATA_IN,
  input  wire logic                   HREADY_IN,
  output logic [31:0]                 HRDATA_OUT,
  output logic                        HREADYOUT_OUT,
  output logic                        HRESP_OUT,
  input  wire logic                   MOTOR_ON_IN,
  input  wire logic [`SLG_CUR_W-1:0]  AVG_CURRENT_IN,
  input  wire logic [`SLG_CUR_W-1:0]  MOTOR_CURRENT_IN,
  input  wire logic [31:0]            FOLLOW_ERR_IN,
  input  wire logic                   MOVE_BUSY_IN,
  output logic                        AMP_ENABLE_OUT,
  output logic                        IN_POSITION_OUT,
  output logic [`SLG_DM_W-1:0]        DERIV_GAIN_OUT,
  output logic                        IRQ_OUT
);
  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic                      addr_phase;
  logic                      wr_pend;
  logic [7:0]                wr_addr;
  logic                      rd_wait;
  logic [7:0]                rd_addr;
  logic [31:0]               rd_value;
  logic [2:0]                ctrl;
  logic [`SLG_ST_W-1:0]      status;
  logic [`SLG_ST_W-1:0]      mask;
  logic [`SLG_CUR_W-1:0]     avg_limit;
  logic [`SLG_CUR_W-1:0]     peak_limit;
  logic [`SLG_DB_W-1:0]      deadband;
  logic [`SLG_DG_W-1:0]      dgain;
  logic [`SLG_DM_W-1:0]      dmax;
  logic [QCW-1:0]            q_count;
  logic                      busy;

  assign addr_phase    = HSEL_IN & HREADY_IN & HTRANS_IN[1] & (HSIZE_IN == 3'h2);
  assign HREADYOUT_OUT = ~rd_wait;
  assign HRESP_OUT     = 1'b0;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= addr_phase & HWRITE_IN;
      rd_wait <= addr_phase & ~HWRITE_IN;
      if (addr_phase) begin
        wr_addr <= HADDR_IN[7:0];
        rd_addr <= HADDR_IN[7:0];
      end
    end
  end

  always_comb begin
    case (rd_addr)
      `SLG_ADDR_CTRL:  rd_value = 32'(ctrl);
      `SLG_ADDR_STAT:  rd_value = 32'(status);
      `SLG_ADDR_MASK:  rd_value = 32'(mask);
      `SLG_ADDR_AVG:   rd_value = 32'(avg_limit);
      `SLG_ADDR_PEAK:  rd_value = 32'(peak_limit);
      `SLG_ADDR_DB:    rd_value = 32'(deadband);
      `SLG_ADDR_DG:    rd_value = 32'(dgain);
      `SLG_ADDR_DM:    rd_value = 32'(dmax);
      `SLG_ADDR_DEFF:  rd_value = 32'(DERIV_GAIN_OUT);
      `SLG_ADDR_QSTAT: rd_value = {31'(q_count), busy};
      default:         rd_value = 32'h0000_0000;
    endcase
  end

  // Reads take one wait state so a write just before is already visible.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HRDATA_OUT <= 32'h0000_0000;
    end else if (rd_wait) begin
      HRDATA_OUT <= rd_value;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl <= 3'h0;
      mask <= '0;
    end else if (wr_pend) begin
      if (wr_addr == `SLG_ADDR_CTRL) begin
        ctrl <= HWDATA_IN[2:0];
      end
      if (wr_addr == `SLG_ADDR_MASK) begin
        mask <= HWDATA_IN[`SLG_ST_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Move-busy pin synchroniser
  // --------------------------------------------------------------------------
  logic busy_s1;
  logic busy_s2;
  logic busy_s3;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      busy_s3 <= 1'b0;
      busy    <= 1'b0;
    end else begin
      busy_s1 <= MOVE_BUSY_IN;
      busy_s2 <= busy_s1;
      busy_s3 <= busy_s2;
      if (busy_s2 == busy_s3) begin
        busy <= busy_s3;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command entry and queue
  // --------------------------------------------------------------------------
  logic                  cmd_wr;
  logic                  imm_valid;
  logic                  push;
  logic                  push_ready;
  logic                  pop;
  logic                  q_empty;
  logic                  q_valid;
  logic [`SLG_CMD_W-1:0] q_data;
  logic [2:0]            imm_op;
  logic [27:0]           imm_val;
  logic [2:0]            q_op;
  logic [27:0]           q_val;
  logic                  imm_ok;
  logic                  q_ok;
  slg_pkg::slg_seq_state_e seq_state;

  assign cmd_wr    = wr_pend & (wr_addr == `SLG_ADDR_CMD);
  assign imm_valid = cmd_wr & ~HWDATA_IN[`SLG_CMD_QUEUED];
  assign push      = cmd_wr & HWDATA_IN[`SLG_CMD_QUEUED];
  assign imm_op    = HWDATA_IN[`SLG_CMD_OP_HI:`SLG_CMD_OP_LO];
  assign imm_val   = HWDATA_IN[`SLG_CMD_VAL_HI:0];
  assign q_op      = q_data[`SLG_CMD_OP_HI:`SLG_CMD_OP_LO];
  assign q_val     = q_data[`SLG_CMD_VAL_HI:0];

  function automatic logic value_ok(input logic [2:0] op, input logic [27:0] v);
    case (op)
      `SLG_OP_AVG:  value_ok = (v <= `SLG_AVG_MAX);
      `SLG_OP_PEAK: value_ok = (v <= `SLG_PEAK_MAX);
      `SLG_OP_DB:   value_ok = (v <= `SLG_DB_MAX);
      `SLG_OP_DG:   value_ok = (v <= `SLG_DG_MAX);
      `SLG_OP_DM:   value_ok = (v <= `SLG_DM_MAX);
      default:      value_ok = 1'b0;
    endcase
  endfunction

  assign imm_ok = imm_valid & value_ok(imm_op, imm_val);
  assign q_ok   = q_valid & value_ok(q_op, q_val);

  slg_cmd_queue #(
    .WIDTH (`SLG_CMD_W),
    .DEPTH (QUEUE_DEPTH),
    .CW    (QCW)
  ) u_queue (
    .clk_in         (CLK_IN),
    .rst_b_in       (RST_B_IN),
    .push_in        (push),
    .push_data_in   (HWDATA_IN[`SLG_CMD_W-1:0]),
    .push_ready_out (push_ready),
    .pop_in         (pop),
    .pop_data_out   (q_data),
    .pop_valid_out  (q_valid),
    .empty_out      (q_empty),
    .count_out      (q_count)
  );

  // Queued commands run one at a time, only between moves.
  assign pop = (seq_state == slg_pkg::SLG_SEQ_IDLE) & ctrl[`SLG_CTRL_RUN] & ~busy & ~q_empty;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      seq_state <= slg_pkg::SLG_SEQ_IDLE;
    end else begin
      case (seq_state)
        slg_pkg::SLG_SEQ_IDLE:  if (pop) begin
          seq_state <= slg_pkg::SLG_SEQ_FETCH;
        end
        slg_pkg::SLG_SEQ_FETCH: seq_state <= slg_pkg::SLG_SEQ_IDLE;
        default:                seq_state <= slg_pkg::SLG_SEQ_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Settings: an immediate update in the same cycle wins over a queued one
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      avg_limit <= `SLG_AVG_RST;
    end else if (imm_ok && imm_op == `SLG_OP_AVG) begin
      avg_limit <= imm_val[`SLG_CUR_W-1:0];
    end else if (q_ok && q_op == `SLG_OP_AVG) begin
      avg_limit <= q_val[`SLG_CUR_W-1:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      peak_limit <= `SLG_PEAK_RST;
    end else if (imm_ok && imm_op == `SLG_OP_PEAK) begin
      peak_limit <= imm_val[`SLG_CUR_W-1:0];
    end else if (q_ok && q_op == `SLG_OP_PEAK) begin
      peak_limit <= q_val[`SLG_CUR_W-1:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      deadband <= `SLG_DB_RST;
    end else if (imm_ok && imm_op == `SLG_OP_DB) begin
      deadband <= imm_val;
    end else if (q_ok && q_op == `SLG_OP_DB) begin
      deadband <= q_val;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dgain <= `SLG_DG_RST;
    end else if (imm_ok && imm_op == `SLG_OP_DG) begin
      dgain <= imm_val[`SLG_DG_W-1:0];
    end else if (q_ok && q_op == `SLG_OP_DG) begin
      dgain <= q_val[`SLG_DG_W-1:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dmax <= `SLG_DM_RST;
    end else if (imm_ok && imm_op == `SLG_OP_DM) begin
      dmax <= imm_val[`SLG_DM_W-1:0];
    end else if (q_ok && q_op == `SLG_OP_DM) begin
      dmax <= q_val[`SLG_DM_W-1:0];
    end
  end

  logic [`SLG_PROD_W-1:0] gain_prod;
  logic [`SLG_PROD_W-1:0] gain_scaled;

  assign gain_prod   = `SLG_PROD_W'(dgain) * `SLG_PROD_W'(dmax);
  assign gain_scaled = gain_prod / `SLG_PCT_DIV;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DERIV_GAIN_OUT <= '0;
    end else begin
      DERIV_GAIN_OUT <= gain_scaled[`SLG_DM_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Supervision, faults and interrupt
  // --------------------------------------------------------------------------
  logic                 avg_over;
  logic                 peak_over;
  logic [31:0]          err_mag;
  logic [`SLG_ST_W-1:0] events;
  logic [`SLG_ST_W-1:0] clr;

  assign avg_over  = MOTOR_ON_IN & (AVG_CURRENT_IN > avg_limit);
  assign peak_over = MOTOR_CURRENT_IN > peak_limit;
  assign err_mag   = FOLLOW_ERR_IN[31] ? (~FOLLOW_ERR_IN + 32'h0000_0001) : FOLLOW_ERR_IN;
  assign events    = {push & ~push_ready,
                      (imm_valid & ~imm_ok) | (q_valid & ~q_ok),
                      peak_over,
                      avg_over};
  assign clr       = (wr_pend && wr_addr == `SLG_ADDR_STAT) ? HWDATA_IN[`SLG_ST_W-1:0] : '0;

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      status <= '0;
    end else begin
      status <= (status & ~clr) | events;
    end
  end

  // The amplifier stays off until both current faults are cleared.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      AMP_ENABLE_OUT <= 1'b0;
    end else begin
      AMP_ENABLE_OUT <= ctrl[`SLG_CTRL_ARM] & ~avg_over & ~peak_over
                        & ~status[`SLG_ST_AVG] & ~status[`SLG_ST_PEAK];
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IN_POSITION_OUT <= 1'b0;
    end else begin
      IN_POSITION_OUT <= ctrl[`SLG_CTRL_INPOS] & (err_mag > 32'(deadband));
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(((status & ~clr) | events) & mask);
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_pop_taken;
    pop;
  endsequence

  sequence s_data_back;
    q_valid && seq_state == slg_pkg::SLG_SEQ_FETCH;
  endsequence

  a_avg_trip_amp: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    avg_over |=> !AMP_ENABLE_OUT && status[`SLG_ST_AVG])
    else $error("Average overcurrent did not disable the amplifier.");

  a_peak_trip_amp: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    peak_over |=> !AMP_ENABLE_OUT && status[`SLG_ST_PEAK])
    else $error("Peak overcurrent did not disable the amplifier.");

  a_queued_in_order: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    s_pop_taken |=> s_data_back ##1 !q_valid)
    else $error("Queued command was not returned one cycle after its pop.");

  a_peak_queued_apply: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    q_ok && q_op == `SLG_OP_PEAK && !(imm_valid && imm_op == `SLG_OP_PEAK)
    |=> peak_limit == $past(q_val[`SLG_CUR_W-1:0]))
    else $error("Queued peak limit was not applied.");

  a_deadband_store: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    imm_ok && imm_op == `SLG_OP_DB |=> deadband == $past(imm_val))
    else $error("Dead band update was not stored.");

  a_inpos_outside: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    ctrl[`SLG_CTRL_INPOS] && err_mag > 32'(deadband) |=> IN_POSITION_OUT)
    else $error("In-position output low while error exceeds dead band.");

  a_inpos_inside: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    err_mag <= 32'(deadband) |=> !IN_POSITION_OUT)
    else $error("In-position output high while error is within dead band.");

  a_gain_scaling: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    $stable(dgain) && $stable(dmax) |=>
    32'(DERIV_GAIN_OUT) == (32'($past(dgain)) * 32'($past(dmax))) / 32'd100)
    else $error("Effective derivative gain is not percent of maximum.");

  a_dmax_replace: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    imm_ok && imm_op == `SLG_OP_DM |=> dmax == $past(imm_val[`SLG_DM_W-1:0]))
    else $error("Derivative maximum was not replaced.");

  a_reject_keeps: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    imm_valid && !imm_ok && !q_valid |=> $stable(dgain) && $stable(dmax)
    && $stable(deadband) && $stable(avg_limit) && $stable(peak_limit)
    && status[`SLG_ST_REJ])
    else $error("Rejected update changed a stored setting.");
endmodule

// ### hw/slg_defines.svh
// Constants for the servo limit and gain configuration block.
`ifndef SLG_DEFINES_SVH
`define SLG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SLG_ADDR_CMD    8'h00
`define SLG_ADDR_CTRL   8'h04
`define SLG_ADDR_STAT   8'h08
`define SLG_ADDR_MASK   8'h0c
`define SLG_ADDR_AVG    8'h10
`define SLG_ADDR_PEAK   8'h14
`define SLG_ADDR_DB     8'h18
`define SLG_ADDR_DG     8'h1c
`define SLG_ADDR_DM     8'h20
`define SLG_ADDR_DEFF   8'h24
`define SLG_ADDR_QSTAT  8'h28

// ----------------------------------------------------------------------------
// Command word layout
// ----------------------------------------------------------------------------
`define SLG_CMD_QUEUED  31
`define SLG_CMD_OP_HI   30
`define SLG_CMD_OP_LO   28
`define SLG_CMD_VAL_HI  27
`define SLG_CMD_W       31

`define SLG_OP_AVG      3'h1
`define SLG_OP_PEAK     3'h2
`define SLG_OP_DB       3'h3
`define SLG_OP_DG       3'h4
`define SLG_OP_DM       3'h5

// ----------------------------------------------------------------------------
// Field widths, limits and reset values (currents in 10 mA units)
// ----------------------------------------------------------------------------
`define SLG_CUR_W       10
`define SLG_DB_W        28
`define SLG_DG_W        7
`define SLG_DM_W        15
`define SLG_PROD_W      22
`define SLG_AVG_MAX     28'h00002ee
`define SLG_PEAK_MAX    28'h0000352
`define SLG_DB_MAX      28'ha000000
`define SLG_DG_MAX      28'h0000063
`define SLG_DM_MAX      28'h0007fff
`define SLG_AVG_RST     10'h2ee
`define SLG_PEAK_RST    10'h352
`define SLG_DB_RST      28'h0000000
`define SLG_DG_RST      7'h1e
`define SLG_DM_RST      15'h190
`define SLG_PCT_DIV     22'h000064

// ----------------------------------------------------------------------------
// Control and status bits
// ----------------------------------------------------------------------------
`define SLG_CTRL_ARM    0
`define SLG_CTRL_INPOS  1
`define SLG_CTRL_RUN    2
`define SLG_ST_AVG      0
`define SLG_ST_PEAK     1
`define SLG_ST_REJ      2
`define SLG_ST_OVF      3
`define SLG_ST_W        4

`endif

// ### hw/slg_pkg.sv
// Types shared by the servo limit and gain configuration block.
package slg_pkg;
  typedef enum logic [1:0] {
    SLG_SEQ_IDLE,
    SLG_SEQ_FETCH
  } slg_seq_state_e;
endpackage

// ### hw/slg_cmd_queue.sv
// Command queue memory for the queued updates, kept in program order.
`timescale 1ns/1ps
module slg_cmd_queue #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             push_in,
  input  wire logic [WIDTH-1:0] push_data_in,
  output logic                  push_ready_out,
  input  wire logic             pop_in,
  output logic [WIDTH-1:0]      pop_data_out,
  output logic                  pop_valid_out,
  output logic                  empty_out,
  output logic [CW-1:0]         count_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             do_push;
  logic             do_pop;

  assign push_ready_out = (count_out != CW'(DEPTH));
  assign empty_out      = (count_out == '0);
  assign do_push        = push_in & push_ready_out;
  assign do_pop         = pop_in & ~empty_out;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= '0;
    end else if (do_push && !do_pop) begin
      count_out <= count_out + CW'(1);
    end else if (do_pop && !do_push) begin
      count_out <= count_out - CW'(1);
    end
  end

  // Read data leaves a register one cycle after the pop.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pop_data_out  <= '0;
      pop_valid_out <= 1'b0;
    end else begin
      pop_valid_out <= do_pop;
      if (do_pop) begin
        pop_data_out <= mem[rd_ptr];
      end
    end
  end
endmodule

// ### testbench/slg_motor_model.sv
// Amplifier and motor model that drives the supervision inputs of the block.
`timescale 1ns/1ps
module slg_motor_model (
  input  wire logic        clk_in,
  input  wire logic        amp_en_in,
  input  wire logic        on_in,
  input  wire logic [9:0]  avg_in,
  input  wire logic [9:0]  pk_in,
  input  wire logic [31:0] err_in,
  output logic             on_out,
  output logic [9:0]       avg_out,
  output logic [9:0]       pk_out,
  output logic [31:0]      err_out
);
  // A disabled amplifier leaves the motor unpowered and carrying no current.
  always @(posedge clk_in) begin
    on_out <= on_in & amp_en_in;
    avg_out <= amp_en_in ? avg_in : 10'h000;
    pk_out <= amp_en_in ? pk_in : 10'h000;
    err_out <= err_in;
  end
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the servo limit and gain configuration block.
`timescale 1ns/1ps
`include "slg_defines.svh"
module testbench;
  logic        clk, rst_b, hsel, hwrite, rdy, resp, amp, inpos, irq, busy, m_on, d_on;
  logic        rd_pend;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, err, d_err;
  logic [9:0]  avg, pk, d_avg, d_pk;
  logic [14:0] dgain;
  logic [31:0] exp_q[$];
  int          num_errors, cmp_count, g, m, v;
  int          lim[6] = '{0, 750, 850, 167772160, 99, 32767};
  logic [7:0]  ra[6] = '{0, `SLG_ADDR_AVG, `SLG_ADDR_PEAK, `SLG_ADDR_DB, `SLG_ADDR_DG,
                         `SLG_ADDR_DM};
  logic [7:0]  rst_a[9] = '{`SLG_ADDR_AVG, `SLG_ADDR_PEAK, `SLG_ADDR_DB, `SLG_ADDR_DG,
                            `SLG_ADDR_DM, `SLG_ADDR_DEFF, `SLG_ADDR_STAT, 8'h3c, 8'h00};
  logic [31:0] rst_v[9] = '{32'h2ee, 32'h352, 0, 32'h1e, 32'h190, 32'h78, 0, 0, 0};
  logic [31:0] dbe[5] = '{32'd50, 32'd51, -32'sd51, -32'sd50, 32'd0};
  logic        dbx[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  slg_servo_config #(.QUEUE_DEPTH(2)) slg_servo_config_i (
    .CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata),
    .HREADY_IN(rdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp),
    .MOTOR_ON_IN(d_on), .AVG_CURRENT_IN(d_avg), .MOTOR_CURRENT_IN(d_pk),
    .FOLLOW_ERR_IN(d_err), .MOVE_BUSY_IN(busy), .AMP_ENABLE_OUT(amp),
    .IN_POSITION_OUT(inpos), .DERIV_GAIN_OUT(dgain), .IRQ_OUT(irq));
  slg_motor_model slg_motor_model_i (
    .clk_in(clk), .amp_en_in(amp), .on_in(m_on), .avg_in(avg), .pk_in(pk),
    .err_in(err), .on_out(d_on), .avg_out(d_avg), .pk_out(d_pk), .err_out(d_err));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Counts: %0d compares, %0d errors", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits for an edge with ready high; a stuck bus ends the run.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  // Read data go to the queue as the expected value.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !wr;
    if (!wr)
      exp_q.push_back(d);
    wait_rdy();
    rd_pend <= 1'b0;
  endtask
  task automatic cmd(input logic q, input logic [2:0] op, input logic [27:0] val);
    bus(1'b1, `SLG_ADDR_CMD, {q, op, val});
  endtask

  always @(posedge clk) begin
    if (rd_pend && rdy === 1'b1 && exp_q.size() > 0)
      chk(hrdata, exp_q.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst_b, hsel, hwrite, rd_pend, busy, m_on, htrans} = '0;
    {haddr, hwdata, err, avg, pk} = '0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(35));
    cyc(4);
    rst_b <= 1'b1;
    cyc(1);
    foreach (rst_a[i]) bus(1'b0, rst_a[i], rst_v[i]);
    chk({amp, inpos, irq, resp, dgain}, 32'h78);
    $display("Reset test done");
    for (int op = 1; op <= 5; op++) begin
      v = $urandom % (lim[op] + 1);
      cmd(1'b0, op[2:0], v[27:0]);
      bus(1'b0, ra[op], v);
      cmd(1'b0, op[2:0], lim[op] + 1);
      bus(1'b0, ra[op], v);
      bus(1'b0, `SLG_ADDR_STAT, 32'h4);
      bus(1'b1, `SLG_ADDR_STAT, 32'h4);
      cmd(1'b0, op[2:0], lim[op]);
      bus(1'b0, ra[op], lim[op]);
    end
    cmd(1'b0, 3'h6, 28'h0);
    bus(1'b0, `SLG_ADDR_STAT, 32'h4);
    g = $urandom % 100;
    m = $urandom % 32768;
    cmd(1'b0, 3'h4, g);
    cmd(1'b0, 3'h5, m);
    cyc(2);
    chk(dgain, (g * m) / 100);
    $display("Immediate update test done");
    bus(1'b1, `SLG_ADDR_STAT, 32'hf);
    bus(1'b1, `SLG_ADDR_MASK, 32'h7);
    bus(1'b1, `SLG_ADDR_CTRL, 32'h1);
    cmd(1'b0, 3'h1, 28'd200);
    m_on <= 1'b1;
    avg <= 10'd200;
    pk <= 10'd850;
    cyc(4);
    chk({amp, irq}, 2'b10);
    avg <= 10'd201;
    cyc(3);
    chk({amp, irq}, 2'b01);
    bus(1'b0, `SLG_ADDR_STAT, 32'h1);
    avg <= 10'd0;
    m_on <= 1'b0;
    bus(1'b1, `SLG_ADDR_STAT, 32'h1);
    cyc(2);
    chk({amp, irq}, 2'b10);
    pk <= 10'd851;
    cyc(3);
    chk({amp, irq}, 2'b01);
    bus(1'b0, `SLG_ADDR_STAT, 32'h2);
    pk <= 10'd0;
    bus(1'b1, `SLG_ADDR_MASK, 32'h0);
    bus(1'b1, `SLG_ADDR_STAT, 32'h2);
    pk <= 10'd851;
    cyc(4);
    chk({amp, irq}, 2'b00);
    pk <= 10'd0;
    bus(1'b1, `SLG_ADDR_MASK, 32'h2);
    cyc(2);
    chk(irq, 1'b1);
    bus(1'b1, `SLG_ADDR_STAT, 32'h2);
    $display("Fault test done");
    cmd(1'b0, 3'h3, 28'd50);
    bus(1'b1, `SLG_ADDR_CTRL, 32'h3);
    foreach (dbe[i]) begin
      err <= dbe[i];
      cyc(3);
      chk(inpos, dbx[i]);
    end
    bus(1'b1, `SLG_ADDR_CTRL, 32'h1);
    err <= 32'd51;
    cyc(3);
    chk(inpos, 1'b0);
    $display("Dead band test done");
    cmd(1'b1, 3'h4, 28'd44);
    cmd(1'b1, 3'h4, 28'd20);
    cmd(1'b1, 3'h3, 28'd7);
    bus(1'b0, `SLG_ADDR_STAT, 32'h8);
    cmd(1'b0, 3'h5, 28'd400);
    bus(1'b0, `SLG_ADDR_DM, 32'd400);
    bus(1'b0, `SLG_ADDR_DG, g);
    busy <= 1'b1;
    cyc(6);
    bus(1'b0, `SLG_ADDR_QSTAT, 32'h5);
    bus(1'b1, `SLG_ADDR_CTRL, 32'h5);
    cyc(10);
    bus(1'b0, `SLG_ADDR_DG, g);
    busy <= 1'b0;
    cyc(20);
    bus(1'b0, `SLG_ADDR_DG, 32'd20);
    chk(dgain, 15'd80);
    cmd(1'b1, 3'h5, 28'd15000);
    cmd(1'b1, 3'h5, 28'd5000);
    cmd(1'b1, 3'h1, 28'd300);
    cmd(1'b1, 3'h2, 28'd400);
    cyc(20);
    bus(1'b0, `SLG_ADDR_DM, 32'd5000);
    bus(1'b0, `SLG_ADDR_AVG, 32'd300);
    bus(1'b0, `SLG_ADDR_PEAK, 32'd400);
    chk(dgain, 15'd1000);
    $display("Queue test done");
    conclude();
  end
endmodule
